// File: verif/alu_checker.sv
module alu_checker
  import alu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic issue,
  input wire alu_req_t req,
  input wire logic flag_load,
  input wire logic [7:0] flag_load_value,
  input wire logic result_valid,
  input wire logic [15:0] result,
  input wire logic result_word,
  input wire logic [7:0] flags
);
  // ----------------------------------------
  // result and flag relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic mag;
  logic adc;
  assign mag = issue && req.op == op_magnitude;
  assign adc = issue && req.op == op_add_carry;
  property p_pulse; issue |=> result_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("no result pulse");
  property p_once; !issue |=> !result_valid; endproperty
  a_once: assert property (p_once) else $error("result pulse too long");
  property p_hold; !issue && !flag_load |=> $stable(flags); endproperty
  a_hold: assert property (p_hold) else $error("flags moved idle");
  property p_keep; issue |=> {flags[7:6], flags[4], flags[1]} == $past({flags[7:6], flags[4], flags[1]}); endproperty
  a_keep: assert property (p_keep) else $error("fixed flags moved");
  property p_z; mag || adc |=> flags[2] == (result_word ? result == 16'h0 : result[7:0] == 8'h0); endproperty
  a_z: assert property (p_z) else $error("zero flag wrong");
  property p_s; mag || adc |=> flags[3] == (result_word ? result[15] : result[7]); endproperty
  a_s: assert property (p_s) else $error("sign flag wrong");
  property p_ovm; mag && !req.byte_size && req.dest.value == word_min_neg |=> flags[5] && result == word_min_neg; endproperty
  a_ovm: assert property (p_ovm) else $error("most negative wrong");
  property p_abs; mag && !req.byte_size |=> result == ($past(req.dest.value[15]) ? -$past(req.dest.value) : $past(req.dest.value)); endproperty
  a_abs: assert property (p_abs) else $error("magnitude wrong");
  property p_add; adc && !req.byte_size |=> {flags[0], result} == {1'b0, $past(req.dest.value)} + $past(req.src.value) + $past(flags[0]); endproperty
  a_add: assert property (p_add) else $error("word sum wrong");
endmodule
bind magnitude_and_carry_add_alu alu_checker chk (.clk(clk), .rstn(rstn), .issue(issue), .req(req),
  .flag_load(flag_load), .flag_load_value(flag_load_value), .result_valid(result_valid),
  .result(result), .result_word(result_word), .flags(flags));

// File: verif/magnitude_and_carry_add_alu_tb.sv
module magnitude_and_carry_add_alu_tb
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and checks
  // ----------------------------------------
  logic clk = 0, rstn = 0, issue = 0, flag_load = 0, result_valid, result_word;
  alu_req_t req = '0;
  logic [7:0] flag_load_value = 8'h00, flags;
  logic [15:0] result;
  int fail_count = 0, tests_run = 0;
  always #2 clk = ~clk;
  magnitude_and_carry_add_alu DUT (.clk(clk), .rstn(rstn), .issue(issue), .req(req),
    .flag_load(flag_load), .flag_load_value(flag_load_value), .result_valid(result_valid),
    .result(result), .result_word(result_word), .flags(flags));
  task chk16(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    chk16({8'h0, g}, {8'h0, e});
  endtask
  // fixed flags u, i, b, d are loaded set so any disturbance shows
  task run(input alu_op_t o, input logic bs, sa, input logic [15:0] s, input logic da,
    input logic [15:0] d, input logic c, input logic [15:0] er, input logic ew, input logic [7:0] ef);
    @(posedge clk);
    #1 flag_load = 1;
    flag_load_value = 8'hd2 | {7'h0, c};
    @(posedge clk);
    #1 flag_load = 0;
    issue = 1;
    req = '{o, bs, '{sa, s}, '{da, d}};
    @(posedge clk);
    #1 issue = 0;
    chk8({7'h0, result_valid}, 8'h01);
    chk16(result, er);
    chk8({7'h0, result_word}, {7'h0, ew});
    // carry after magnitude is left unchecked on purpose
    chk8(flags & (o == op_magnitude ? 8'hfe : 8'hff), ef);
  endtask
  task t_mag;
    run(op_magnitude, 0, 0, 16'h0, 0, 16'hfffb, 0, 16'h0005, 1, 8'hd2);
    run(op_magnitude, 1, 0, 16'h0, 0, 16'h1280, 0, 16'h1280, 0, 8'hfa);
    run(op_magnitude, 0, 0, 16'h0, 0, 16'h8000, 1, 16'h8000, 1, 8'hfa);
    run(op_magnitude, 0, 0, 16'h0, 0, 16'h0000, 0, 16'h0000, 1, 8'hd6);
    run(op_magnitude, 1, 0, 16'h0, 0, 16'h34fe, 0, 16'h3402, 0, 8'hd2);
  endtask
  // no byte scenario puts address registers on both operands
  task t_adc;
    run(op_add_carry, 0, 0, 16'h0000, 0, 16'h7fff, 1, 16'h8000, 1, 8'hfa);
    run(op_add_carry, 0, 0, 16'h0001, 0, 16'hffff, 0, 16'h0000, 1, 8'hd7);
    run(op_add_carry, 1, 0, 16'h99f0, 1, 16'h1200, 0, 16'h12f0, 1, 8'hd2);
    run(op_add_carry, 1, 1, 16'hab05, 0, 16'h3410, 1, 16'h3416, 0, 8'hd2);
    run(op_add_carry, 1, 0, 16'h0001, 0, 16'h007f, 0, 16'h0080, 0, 8'hfa);
    run(op_add_carry, 1, 0, 16'h0001, 0, 16'h00ff, 0, 16'h0000, 0, 8'hd7);
  endtask
  // back-to-back issues chain the carry; a colliding flag load loses
  task t_chain;
    @(posedge clk);
    #1 flag_load = 1;
    flag_load_value = 8'hd2;
    @(posedge clk);
    #1 issue = 1;
    flag_load_value = 8'h00;
    req = '{op_add_carry, 1'b0, '{1'b0, 16'h0001}, '{1'b0, 16'hffff}};
    @(posedge clk);
    #1 flag_load = 0;
    req = '{op_add_carry, 1'b0, '{1'b0, 16'h0000}, '{1'b0, 16'h0010}};
    chk16(result, 16'h0000);
    chk8(flags, 8'hd7);
    @(posedge clk);
    #1 req = '{alu_op_t'(2'h3), 1'b0, '{1'b0, 16'h0000}, '{1'b0, 16'h5a5a}};
    chk16(result, 16'h0011);
    chk8(flags, 8'hd2);
    @(posedge clk);
    #1 issue = 0;
    chk8({7'h0, result_valid}, 8'h01);
    chk16(result, 16'h5a5a);
    chk8(flags, 8'hd2);
    @(posedge clk);
    #1 chk8({7'h0, result_valid}, 8'h00);
  endtask
  task conclude;
    $display("mismatches %0d of %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1;
    chk16(result, 16'h0000);
    chk8(flags, 8'h00);
    t_mag;
    t_adc;
    t_chain;
    conclude;
  end
endmodule

// File: verilog/alu_pkg.sv
package alu_pkg;

  // ----------------------------------------------------------------
  // operand widths and constants
  // ----------------------------------------------------------------
  localparam int unsigned word_w = 16;
  localparam int unsigned byte_w = 8;
  localparam logic [15:0] word_min_neg = 16'h8000;
  localparam logic [7:0] byte_min_neg = 8'h80;

  // flag register bit positions
  localparam int unsigned flag_c_pos = 0;
  localparam int unsigned flag_d_pos = 1;
  localparam int unsigned flag_z_pos = 2;
  localparam int unsigned flag_s_pos = 3;
  localparam int unsigned flag_b_pos = 4;
  localparam int unsigned flag_o_pos = 5;
  localparam int unsigned flag_i_pos = 6;
  localparam int unsigned flag_u_pos = 7;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [15:0] result_reset = 16'h0000;

  // latency from issue to result, in cycles
  localparam int unsigned alu_latency = 1;

  typedef enum logic [1:0] {
    op_magnitude = 2'h1,
    op_add_carry = 2'h2
  } alu_op_t;

  // operand is one of the two address registers
  typedef struct packed {
    logic is_addr_reg;
    logic [15:0] value;
  } operand_t;

  typedef struct packed {
    alu_op_t op;
    logic byte_size;
    operand_t src;
    operand_t dest;
  } alu_req_t;

endpackage

// File: verilog/magnitude_and_carry_add_alu.sv
// Function
// - magnitude replaces destination with its absolute value at selected width.
// - magnitude sets overflow when destination was most negative value, else clears.
// - magnitude sign flag follows result msb at selected width.
// - magnitude zero flag set when result at selected width is zero.
// - carry after magnitude is undefined; nobody may rely on it.
// - add-with-carry stores destination plus source plus carry at selected width.
// - byte add into address register zero-extends source, computes 16 bits.
// - byte add from address register uses only its low eight bits.
// - flags not affected keep value; u, i, b, d always untouched.
// - add-with-carry overflow set on signed range exit, else cleared.
// - add-with-carry carry set when unsigned sum exceeds width, else cleared.
// - add-with-carry sign follows result msb, zero set only for zero result.
module magnitude_and_carry_add_alu
  import alu_pkg::*;
#(
  parameter int unsigned data_w = word_w, // full operand width
  parameter int unsigned part_w = byte_w // byte operand width
) (
  input wire logic clk, // core clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic issue, // one-cycle request strobe
  input wire alu_req_t req, // operation, size and operands
  input wire logic flag_load, // core writes the flag register
  input wire logic [7:0] flag_load_value, // value for flag_load
  output logic result_valid, // one-cycle pulse with result
  output logic [15:0] result, // value to write back to destination
  output logic result_word, // result is 16 bits wide
  output logic [7:0] flags // current flag register
);

  // ----------------------------------------------------------------
  // combinational datapath
  // ----------------------------------------------------------------
  logic [15:0] next_result;
  logic next_word;
  logic next_o;
  logic next_c;
  logic next_s;
  logic next_z;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // the datapath and flag rules are written for these two widths only
  if (data_w != word_w) begin : g_bad_data_w
    $error("data_w must be 16");
  end
  if (part_w != byte_w) begin : g_bad_part_w
    $error("part_w must be 8");
  end

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // only the two known operations may touch the flags
  function automatic logic op_known(input alu_op_t op);
    op_known = (op == op_magnitude) || (op == op_add_carry);
  endfunction

  // most negative pattern maps to itself: no positive twin exists
  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction

  function automatic logic [7:0] abs8(input logic [7:0] v);
    abs8 = v[7] ? 8'(-v) : v;
  endfunction

  // signed overflow from the operand and result sign bits
  function automatic logic add_ovf(input logic sa, input logic sb, input logic sr);
    add_ovf = (sa == sb) && (sr != sa);
  endfunction

  function automatic logic is_zero(input logic [15:0] v, input logic wide);
    is_zero = wide ? (v == 16'h0000) : (v[7:0] == 8'h00);
  endfunction

  function automatic logic msb_of(input logic [15:0] v, input logic wide);
    msb_of = wide ? v[15] : v[7];
  endfunction

  // ----------------------------------------------------------------
  // magnitude path
  // ----------------------------------------------------------------
  logic [15:0] mag_result;
  logic mag_o;

  always_comb begin
    if (req.byte_size) begin
      // upper byte passes through untouched in byte size
      mag_result = {req.dest.value[15:8], abs8(req.dest.value[7:0])};
      mag_o = (req.dest.value[7:0] == byte_min_neg);
    end else begin
      mag_result = abs16(req.dest.value);
      mag_o = (req.dest.value == word_min_neg);
    end
  end

  // ----------------------------------------------------------------
  // add-with-carry path
  // ----------------------------------------------------------------
  logic [15:0] add_a;
  logic [15:0] add_b;
  logic [16:0] add_sum;
  logic add_word;
  logic [15:0] add_result;
  logic add_o;
  logic add_c;

  // issuer keeps address registers off both byte operands
  always_comb begin
    add_word = ~req.byte_size;
    if (req.byte_size && req.dest.is_addr_reg) begin
      add_a = req.dest.value;
      add_b = {8'h00, req.src.value[7:0]};
      add_word = 1'b1;
    end else if (req.byte_size) begin
      add_a = {8'h00, req.dest.value[7:0]};
      add_b = {8'h00, req.src.value[7:0]};
    end else begin
      add_a = req.dest.value;
      add_b = req.src.value;
    end
  end

  always_comb begin
    add_sum = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, flags[flag_c_pos]};
    if (add_word) begin
      add_result = add_sum[15:0];
      add_c = add_sum[16];
      add_o = add_ovf(add_a[15], add_b[15], add_sum[15]);
    end else begin
      // byte result keeps the destination's upper byte
      add_result = {req.dest.value[15:8], add_sum[7:0]};
      add_c = add_sum[8];
      add_o = add_ovf(add_a[7], add_b[7], add_sum[7]);
    end
  end

  // ----------------------------------------------------------------
  // operation select
  // ----------------------------------------------------------------
  always_comb begin
    next_result = req.dest.value;
    next_word = ~req.byte_size;
    next_o = flags[flag_o_pos];
    next_c = flags[flag_c_pos];
    case (req.op)
      op_magnitude: begin
        next_result = mag_result;
        next_o = mag_o;
        // carry is undefined here; keeping it costs no logic
        next_c = flags[flag_c_pos];
      end
      op_add_carry: begin
        next_result = add_result;
        next_word = add_word;
        next_o = add_o;
        next_c = add_c;
      end
      default: begin
        next_result = req.dest.value;
      end
    endcase
    next_s = msb_of(next_result, next_word);
    next_z = is_zero(next_result, next_word);
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= issue;
    end
  end

  // result holds until the next issue so writeback may take it late
  always_ff @(posedge clk) begin
    if (!rstn) begin
      result <= result_reset;
    end else if (issue) begin
      result <= next_result;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      result_word <= 1'b0;
    end else if (issue) begin
      result_word <= next_word;
    end
  end

  // ----------------------------------------------------------------
  // flag register
  // ----------------------------------------------------------------
  // an issued magnitude or add-with-carry wins over a same-cycle flag load; the load is
  // lost then, so the core must not collide the two on purpose
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags <= flags_reset;
    end else if (issue && op_known(req.op)) begin
      flags[flag_o_pos] <= next_o;
      flags[flag_s_pos] <= next_s;
      flags[flag_z_pos] <= next_z;
      flags[flag_c_pos] <= next_c;
    end else if (flag_load) begin
      flags <= flag_load_value;
    end
  end

endmodule
